// ==== rtl/fnd_defines.svh ====
// Purpose: Constants of the fractional-N feedback divider: register map, field positions, reset values.
// Assumes: Classic Wishbone slave with 32-bit data and one aligned word per register.
// Notes:   Offsets are byte addresses; bits above each field read as zero.
// Operation
// - With the reference mode bit at one the reference goes through the differential buffer and its current source is on.
// - With the reference mode bit at zero the reference comes only from the single-ended pin and the current source is off.
// - The phase-detector rate is the reference times one plus the doubler bit over the count times one plus the halver bit.
// - The reference counter is ten bits wide and divides by every ratio from one through 1023.
// - The feedback divide value is the integer part plus coarse plus fine over fine modulus, all over the coarse modulus.
// - At lock the oscillator runs at the phase-detector rate times the feedback divide value, before output division.
// - The coarse fraction numerator accepts every value from zero through 16777215.
// - The fine fraction numerator is 14 bits wide and accepts zero through 16383.
// - The coarse modulus is fixed at two to the twenty-fourth and cannot be programmed.
// - With both fraction numerators at zero the divider runs in integer-N mode on the integer part alone.
// - Without exact channel spacing the two moduli act together as one 38-bit fractional denominator.
// - Fractions, fine modulus, doubler, halver and reference count take effect only at the next integer-part write.
`ifndef FND_DEFINES_SVH
`define FND_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define FND_ADDR_INT       8'h00
`define FND_ADDR_COARSE    8'h04
`define FND_ADDR_FINE      8'h08
`define FND_ADDR_FINE_MOD  8'h0C
`define FND_ADDR_REF_CFG   8'h10
`define FND_ADDR_STATUS    8'h14

// ****************************************************************
// Field positions of the reference configuration and status words
// ****************************************************************
`define FND_REF_RCOUNT_LSB 0
`define FND_REF_RCOUNT_MSB 9
`define FND_REF_DOUBLER    10
`define FND_REF_HALVER     11
`define FND_REF_MODE       12
`define FND_STAT_INTMODE   17

// ****************************************************************
// Reset values and coarse modulus exponent
// ****************************************************************
`define FND_RST_INT        16'h0017
`define FND_RST_COARSE     24'h00_0000
`define FND_RST_FINE       14'h0000
`define FND_RST_FINE_MOD   14'h0002
`define FND_RST_RCOUNT     10'h001
`define FND_COARSE_MOD_LOG 24

`endif

// ==== rtl/fnd_pkg.sv ====
// Purpose: Types shared by the fractional-N feedback divider.
// Assumes: Constants live in fnd_defines.svh.
// Notes:   Structs group the double-buffered settings.
package fnd_pkg;

    typedef struct packed {
        logic        halver;
        logic        doubler;
        logic [9:0]  rcount;
    } fnd_ref_cfg_t;

    typedef struct packed {
        logic [23:0] coarse;
        logic [13:0] fine;
        logic [13:0] fine_mod;
    } fnd_frac_cfg_t;

endpackage

// ==== rtl/fnd_divider.sv ====
// Purpose: Reference path, fractional accumulator and feedback counter of a fractional-N synthesizer.
// Assumes: Reference and oscillator levels are sampled as synchronous inputs of core_clk.
// Notes:   Settings sit in shadow registers until the integer part is written.
//          The reference mode bit acts at once; it is not double-buffered.
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "fnd_defines.svh"

module fnd_divider
    import fnd_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        single_ended_reference_pin,
    input  wire logic        ref_diff_p,
    input  wire logic        ref_diff_n,
    input  wire logic        vco_level,
    output logic             diff_buffer_current_en,
    output logic             single_ended_switch_closed,
    output logic             pfd_ref_pulse,
    output logic             pfd_fb_pulse,
    output logic      [16:0] feedback_divide_value,
    output logic             integer_mode
);

    // ****************************************************************
    // Byte-lane merge
    // ****************************************************************
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_w, input logic [31:0] new_w,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic          ack_r;
    logic [31:0]   rdat_r;
    logic [31:0]   rdat_nxt;
    logic [15:0]   int_r;
    logic          mode_r;
    fnd_frac_cfg_t frac_shd_r;
    fnd_frac_cfg_t frac_act_r;
    fnd_ref_cfg_t  ref_shd_r;
    fnd_ref_cfg_t  ref_act_r;

    // The pending acknowledge blocks a second take of one request, so each access writes once.
    wire        req       = wb_cyc_i & wb_stb_i & ~ack_r;
    wire        wr        = req & wb_we_i;
    wire        wr_int    = wr & (wb_adr_i == `FND_ADDR_INT);
    wire        wr_coarse = wr & (wb_adr_i == `FND_ADDR_COARSE);
    wire        wr_fine   = wr & (wb_adr_i == `FND_ADDR_FINE);
    wire        wr_fmod   = wr & (wb_adr_i == `FND_ADDR_FINE_MOD);
    wire        wr_ref    = wr & (wb_adr_i == `FND_ADDR_REF_CFG);

    wire [31:0] int_word    = {16'h0000, int_r};
    wire [31:0] coarse_word = {8'h00, frac_shd_r.coarse};
    wire [31:0] fine_word   = {18'h0_0000, frac_shd_r.fine};
    wire [31:0] fmod_word   = {18'h0_0000, frac_shd_r.fine_mod};
    wire [31:0] ref_word    = {19'h0_0000, mode_r, ref_shd_r.halver, ref_shd_r.doubler, ref_shd_r.rcount};
    // Status lets software watch the running cycle without touching the counters.
    wire [31:0] stat_word   = {14'h0000, integer_mode, feedback_divide_value};

    // Byte enables merge into the current word, so partial writes keep the other bytes.
    wire [31:0] int_merge    = merge_lanes(int_word, wb_dat_i, wb_sel_i);
    wire [31:0] coarse_merge = merge_lanes(coarse_word, wb_dat_i, wb_sel_i);
    wire [31:0] fine_merge   = merge_lanes(fine_word, wb_dat_i, wb_sel_i);
    wire [31:0] fmod_merge   = merge_lanes(fmod_word, wb_dat_i, wb_sel_i);
    wire [31:0] ref_merge    = merge_lanes(ref_word, wb_dat_i, wb_sel_i);

    // Unmapped addresses answer with zero so a stray read never hangs the bus.
    always_comb begin
        case (wb_adr_i)
            `FND_ADDR_INT:      rdat_nxt = int_word;
            `FND_ADDR_COARSE:   rdat_nxt = coarse_word;
            `FND_ADDR_FINE:     rdat_nxt = fine_word;
            `FND_ADDR_FINE_MOD: rdat_nxt = fmod_word;
            `FND_ADDR_REF_CFG:  rdat_nxt = ref_word;
            `FND_ADDR_STATUS:   rdat_nxt = stat_word;
            default:            rdat_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r  <= req;
            rdat_r <= rdat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // ****************************************************************
    // Shadow and active settings
    // ****************************************************************
    // Reads of the setting registers return the staged values, not the ones in use.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            int_r      <= `FND_RST_INT;
            mode_r     <= 1'b0;
            frac_shd_r <= '{`FND_RST_COARSE, `FND_RST_FINE, `FND_RST_FINE_MOD};
            ref_shd_r  <= '{1'b0, 1'b0, `FND_RST_RCOUNT};
        end else begin
            if (wr_int) int_r <= int_merge[15:0];
            if (wr_coarse) frac_shd_r.coarse <= coarse_merge[23:0];
            if (wr_fine) frac_shd_r.fine <= fine_merge[13:0];
            if (wr_fmod) frac_shd_r.fine_mod <= fmod_merge[13:0];
            if (wr_ref) begin
                ref_shd_r.rcount  <= ref_merge[`FND_REF_RCOUNT_MSB:`FND_REF_RCOUNT_LSB];
                ref_shd_r.doubler <= ref_merge[`FND_REF_DOUBLER];
                ref_shd_r.halver  <= ref_merge[`FND_REF_HALVER];
                mode_r            <= ref_merge[`FND_REF_MODE];
            end
        end
    end

    // The mode bit stays out of the shadow set so the input buffer can settle
    // before the integer write restarts the counters.
    // load on integer write
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            frac_act_r <= '{`FND_RST_COARSE, `FND_RST_FINE, `FND_RST_FINE_MOD};
            ref_act_r  <= '{1'b0, 1'b0, `FND_RST_RCOUNT};
        end else if (wr_int) begin
            frac_act_r <= frac_shd_r;
            ref_act_r  <= ref_shd_r;
        end
    end

    // ****************************************************************
    // Reference input selection
    // ****************************************************************
    // differential buffer on
    assign diff_buffer_current_en     = mode_r;
    assign single_ended_switch_closed = ~mode_r;

    // A differential level counts as high only with p high and n low, so a common-mode glitch reads low.
    wire ref_level = mode_r ? (ref_diff_p & ~ref_diff_n) : single_ended_reference_pin;

    // ****************************************************************
    // Reference path: doubler, halver, counter
    // ****************************************************************
    logic       ref_level_d_r;
    logic       halver_tgl_r;
    logic [9:0] r_cnt_r;
    logic       ref_pulse_r;

    wire       ref_rise  = ref_level & ~ref_level_d_r;
    wire       ref_fall  = ~ref_level & ref_level_d_r;
    // Limitation: with the doubler on, reference edges must stay two cycles apart or pulses merge.
    // doubler uses both edges
    wire       dbl_pulse = ref_act_r.doubler ? (ref_rise | ref_fall) : ref_rise;
    // The halver phase restarts with every integer write, so it lines up with the new count.
    wire       hlv_pulse = ref_act_r.halver ? (dbl_pulse & halver_tgl_r) : dbl_pulse;
    // A zero count is treated as divide by one so the detector never starves.
    wire [9:0] r_max     = (ref_act_r.rcount == 10'h000) ? 10'h000 : (ref_act_r.rcount - 10'h001);
    wire       r_wrap    = hlv_pulse & (r_cnt_r >= r_max);

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ref_level_d_r <= 1'b0;
            halver_tgl_r  <= 1'b0;
            r_cnt_r       <= 10'h000;
            ref_pulse_r   <= 1'b0;
        end else begin
            ref_level_d_r <= ref_level;
            ref_pulse_r   <= r_wrap;
            if (wr_int) begin
                halver_tgl_r <= 1'b0;
                r_cnt_r      <= 10'h000;
            end else begin
                if (dbl_pulse) halver_tgl_r <= ~halver_tgl_r;
                if (r_wrap) r_cnt_r <= 10'h000;
                else if (hlv_pulse) r_cnt_r <= r_cnt_r + 10'h001;
            end
        end
    end

    assign pfd_ref_pulse = ref_pulse_r;

    // ****************************************************************
    // Fractional accumulator
    // ****************************************************************
    // First-order carry chain: the fine carry feeds the coarse sum, whose top bit adds one
    // to the integer part. Higher-order noise shaping was traded for a value that never
    // strays beyond integer plus one, which keeps the feedback counter simple.
    logic [13:0] fine_acc_r;
    logic [23:0] coarse_acc_r;
    logic [16:0] n_cur_r;
    logic [16:0] n_cnt_r;
    logic        vco_level_d_r;
    logic        fb_pulse_r;

    // A fine numerator at or above the modulus is a software error: the residue then stops shrinking.
    wire [14:0] fine_sum   = {1'b0, fine_acc_r} + {1'b0, frac_act_r.fine};
    wire        fine_carry = (fine_sum >= {1'b0, frac_act_r.fine_mod});
    wire [14:0] fine_diff  = fine_sum - {1'b0, frac_act_r.fine_mod};
    wire [24:0] coarse_sum = {1'b0, coarse_acc_r} + {1'b0, frac_act_r.coarse} + {24'h00_0000, fine_carry};
    wire        int_only   = (frac_act_r.coarse == 24'h00_0000) & (frac_act_r.fine == 14'h0000);
    wire        coarse_carry = coarse_sum[`FND_COARSE_MOD_LOG] & ~int_only;
    wire [16:0] n_next     = {1'b0, int_r} + {16'h0000, coarse_carry};

    // ****************************************************************
    // Feedback counter
    // ****************************************************************
    wire vco_rise = vco_level & ~vco_level_d_r;
    // The count compares against the value in use, so only an integer write, which restarts the count, cuts the running cycle short.
    wire n_wrap   = vco_rise & (n_cnt_r + 17'h0_0001 >= n_cur_r);

    // A wrap in the cycle of an integer write is dropped, so the detector never sees a half cycle.

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            vco_level_d_r <= 1'b0;
            fine_acc_r    <= 14'h0000;
            coarse_acc_r  <= 24'h00_0000;
            n_cur_r       <= {1'b0, `FND_RST_INT};
            n_cnt_r       <= 17'h0_0000;
            fb_pulse_r    <= 1'b0;
        end else begin
            vco_level_d_r <= vco_level;
            fb_pulse_r    <= n_wrap & ~wr_int;
            if (wr_int) begin
                // Restart clean so the new value is not mixed with a stale residue.
                fine_acc_r   <= 14'h0000;
                coarse_acc_r <= 24'h00_0000;
                n_cur_r      <= {1'b0, int_merge[15:0]};
                n_cnt_r      <= 17'h0_0000;
            end else if (n_wrap) begin
                fine_acc_r   <= fine_carry ? fine_diff[13:0] : fine_sum[13:0];
                coarse_acc_r <= int_only ? 24'h00_0000 : coarse_sum[23:0];
                n_cur_r      <= n_next;
                n_cnt_r      <= 17'h0_0000;
            end else if (vco_rise) begin
                n_cnt_r <= n_cnt_r + 17'h0_0001;
            end
        end
    end

    assign pfd_fb_pulse          = fb_pulse_r;
    assign feedback_divide_value = n_cur_r;
    assign integer_mode          = int_only;

    // ****************************************************************
    // Assertions: register bus
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_ack_single_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Acknowledge held longer than one cycle.");
    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("Request not acknowledged in the next cycle.");
    a_status_readback: assert property (req && !wb_we_i && wb_adr_i == `FND_ADDR_STATUS
                                         |=> wb_dat_o[16:0] == $past(feedback_divide_value))
        else $error("Status read did not return the current divide value.");

    // ****************************************************************
    // Assertions: reference path
    // ****************************************************************
    a_diff_mode_on: assert property (mode_r |-> diff_buffer_current_en && !single_ended_switch_closed)
        else $error("Differential mode without buffer current.");
    a_single_mode_off: assert property (!mode_r |-> !diff_buffer_current_en && single_ended_switch_closed)
        else $error("Single-ended mode with buffer current on.");
    a_mode_immediate: assert property (wr_ref |=> mode_r == $past(ref_merge[`FND_REF_MODE]))
        else $error("Reference mode write did not act at once.");
    a_ref_count_range: assert property (r_cnt_r <= r_max || $past(wr_int))
        else $error("Reference counter past its ratio.");
    a_ref_pulse_cause: assert property (pfd_ref_pulse |-> $past(hlv_pulse))
        else $error("Detector pulse without a divided reference edge.");
    a_ref_restart: assert property (wr_int |=> r_cnt_r == 10'h000 && !halver_tgl_r)
        else $error("Integer write did not restart the reference divider.");
    a_ref_deferred: assert property (wr_ref && !wr_int |=> $stable(ref_act_r))
        else $error("Reference settings took effect before integer write.");

    // ****************************************************************
    // Assertions: accumulator and feedback counter
    // ****************************************************************
    a_shadow_deferred: assert property (wr_coarse && !wr_int |=> $stable(frac_act_r.coarse))
        else $error("Coarse fraction took effect before integer write.");
    a_fine_deferred: assert property (wr_fine && !wr_int |=> $stable(frac_act_r.fine))
        else $error("Fine fraction took effect before integer write.");
    a_shadow_loaded: assert property (wr_int |=> frac_act_r == $past(frac_shd_r) && ref_act_r == $past(ref_shd_r))
        else $error("Integer write did not load shadow settings.");
    a_int_load_value: assert property (wr_int |=> feedback_divide_value == {1'b0, $past(int_merge[15:0])})
        else $error("Integer write did not set the next divide value.");
    a_load_no_pulse: assert property (wr_int |=> !pfd_fb_pulse)
        else $error("Feedback pulse in the cycle after an integer write.");
    a_fb_pulse_cause: assert property (pfd_fb_pulse |-> $past(n_wrap))
        else $error("Feedback pulse without a completed count.");
    a_value_steady: assert property (!n_wrap && !wr_int |=> $stable(feedback_divide_value))
        else $error("Divide value changed inside a feedback cycle.");
    a_accum_steady: assert property (!n_wrap && !wr_int |=> $stable(fine_acc_r) && $stable(coarse_acc_r))
        else $error("Accumulator moved without a feedback wrap.");
    a_int_mode_value: assert property (int_only && n_wrap && !wr_int |=> n_cur_r == {1'b0, int_r})
        else $error("Integer mode produced a fractional value.");
    a_coarse_acc_idle: assert property (int_only && n_wrap && !wr_int |=> coarse_acc_r == 24'h00_0000)
        else $error("Coarse accumulator moved in integer mode.");
    a_value_bounds: assert property (n_wrap && !wr_int |=> n_cur_r - {1'b0, int_r} <= 17'h0_0001)
        else $error("Cycle divide value outside integer plus one.");
    a_fine_residue: assert property (frac_act_r.fine_mod >= 14'h0002 && frac_act_r.fine < frac_act_r.fine_mod
                                     && fine_acc_r < frac_act_r.fine_mod |=> fine_acc_r < frac_act_r.fine_mod)
        else $error("Fine residue reached the modulus.");

    c_ref_pulse:    cover property (pfd_ref_pulse);
    c_fb_pulse:     cover property (pfd_fb_pulse);
    c_carry_cycle:  cover property (n_wrap && coarse_carry);
    c_int_reload:   cover property (wr_int ##[1:300] pfd_fb_pulse);
    c_diff_ref:     cover property (diff_buffer_current_en && pfd_ref_pulse);

endmodule // fnd_divider

// ==== test/fnd_osc_model.sv ====
// Purpose: Reference and oscillator stand-ins for the feedback divider bench.
// Assumes: Levels change by non-blocking assignment just after a rising core_clk edge.
// Notes:   The spare tone feeds whichever reference input is not selected.
`timescale 1ns/1ps

module fnd_osc_model #(
    parameter int REF_HALF = 2,
    parameter int ALT_HALF = 3,
    parameter int VCO_HALF = 1
) (
    input  wire logic core_clk,
    output logic      ref_level,
    output logic      alt_level,
    output logic      vco_level
);
    int ref_cnt = 0;
    int alt_cnt = 0;
    int vco_cnt = 0;

    initial begin
        ref_level = 1'b0;
        alt_level = 1'b0;
        vco_level = 1'b0;
    end

    // Each tone holds every level for at least one whole cycle, so every edge is sampled.
    always @(posedge core_clk) begin
        ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
        alt_cnt <= (alt_cnt == ALT_HALF - 1) ? 0 : alt_cnt + 1;
        vco_cnt <= (vco_cnt == VCO_HALF - 1) ? 0 : vco_cnt + 1;
        if (ref_cnt == REF_HALF - 1) ref_level <= ~ref_level;
        if (alt_cnt == ALT_HALF - 1) alt_level <= ~alt_level;
        if (vco_cnt == VCO_HALF - 1) vco_level <= ~vco_level;
    end
endmodule // fnd_osc_model

// ==== test/testbench.sv ====
// Purpose: Self-checking bench of the fractional-N feedback divider.
// Assumes: Reference edges every two cycles, oscillator rising edge every two cycles.
// Notes:   Pulse spacing is measured, so latency offsets cancel out.
`timescale 1ns/1ps
`include "fnd_defines.svh"

module testbench;
    import fnd_pkg::*;
    typedef struct packed {
        logic [15:0] int_v;
        logic [23:0] coarse;
        logic [9:0]  rcount;
        logic        dbl;
        logic        hlv;
        logic        mode;
    } fnd_row_t;

    logic        core_clk = 1'b0;
    logic        reset_n  = 1'b0;
    logic        wb_cyc   = 1'b0;
    logic        wb_stb   = 1'b0;
    logic        wb_we    = 1'b0;
    logic [7:0]  wb_adr   = 8'h00;
    logic [3:0]  wb_sel   = 4'h0;
    logic [31:0] wb_wdat  = 32'h0000_0000;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic        mode_sel = 1'b0;
    logic        ref_lvl, alt_lvl, vco_lvl, diff_p, diff_en, se_closed, ref_pulse, fb_pulse, int_mode;
    logic [16:0] fb_value;
    logic [31:0] q;
    int          n_mismatch = 0;
    int          tests_run  = 0;
    int          cyc, vs, rr;
    fnd_row_t    r;
    fnd_row_t    rows[6] = '{'{16'd23, 24'h00_0000, 10'd1, 1'b0, 1'b0, 1'b0},
                            '{16'd75, 24'h80_0000, 10'd2, 1'b1, 1'b0, 1'b1},
                            '{16'd100, 24'h40_0000, 10'd3, 1'b0, 1'b1, 1'b0},
                            '{16'd23, 24'h40_0000, 10'd5, 1'b1, 1'b0, 1'b1},
                            '{16'd300, 24'h00_0000, 10'd1023, 1'b1, 1'b1, 1'b1},
                            '{16'd23, 24'h00_0000, 10'd0, 1'b0, 1'b0, 1'b0}};
    logic [7:0]  ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    logic [31:0] rv[7] = '{32'h0000_0017, 32'h0000_0000, 32'h0000_0000, 32'h0000_0002,
                           32'h0000_0001, 32'h0002_0017, 32'h0000_0000};

    assign diff_p = mode_sel ? ref_lvl : alt_lvl;

    fnd_osc_model fnd_osc_model_inst (.core_clk(core_clk), .ref_level(ref_lvl), .alt_level(alt_lvl),
                                      .vco_level(vco_lvl));

    fnd_divider fnd_divider_inst (.core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .single_ended_reference_pin(mode_sel ? alt_lvl : ref_lvl), .ref_diff_p(diff_p),
        .ref_diff_n(~diff_p), .vco_level(vco_lvl), .diff_buffer_current_en(diff_en),
        .single_ended_switch_closed(se_closed), .pfd_ref_pulse(ref_pulse), .pfd_fb_pulse(fb_pulse),
        .feedback_divide_value(fb_value), .integer_mode(int_mode));

    always #50 core_clk = ~core_clk;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task stop_test;
        if (n_mismatch == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel} <= {2'b11, we, a, d, 4'hF};
        do @(posedge core_clk); while (wb_ack !== 1'b1);
        q = wb_rdat;
        {wb_cyc, wb_stb} <= 2'b00;
    endtask

    // Counts cycles over n pulse intervals and sums the divide values that start them.
    task automatic span(input logic fb, input int n);
        cyc = 0;
        vs  = 0;
        do @(posedge core_clk); while ((fb ? fb_pulse : ref_pulse) !== 1'b1);
        repeat (n) begin
            vs += int'(fb_value);
            do begin
                @(posedge core_clk);
                cyc++;
            end while ((fb ? fb_pulse : ref_pulse) !== 1'b1);
        end
    endtask

    initial begin
        #6_000_000;
        n_mismatch++;
        stop_test();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        check({diff_en, se_closed, int_mode}, 3'b011);
        for (int i = 0; i < 7; i++) begin
            wb_xfer(1'b0, ra[i], 32'h0);
            check(q, rv[i]);
        end
        for (int i = 0; i < 6; i++) begin
            r = rows[i];
            wb_xfer(1'b1, `FND_ADDR_COARSE, {8'h00, r.coarse});
            wb_xfer(1'b1, `FND_ADDR_REF_CFG, {19'h0, r.mode, r.hlv, r.dbl, r.rcount});
            mode_sel <= r.mode;
            wb_xfer(1'b1, `FND_ADDR_INT, {16'h0, r.int_v});
            rr = (r.rcount == 10'd0) ? 1 : int'(r.rcount);
            span(1'b0, 2);
            check(cyc, 8 * rr * (1 + r.hlv) / (1 + r.dbl));
            span(1'b1, 8);
            check(vs, 8 * r.int_v + ((8 * longint'(r.coarse)) >> 24));
            check(cyc, 2 * vs);
            check(int_mode, r.coarse == 24'h0);
            check({diff_en, se_closed}, {r.mode, ~r.mode});
        end
        // Staged settings must not act before the integer part is written.
        wb_xfer(1'b1, `FND_ADDR_COARSE, 32'h0080_0000);
        wb_xfer(1'b1, `FND_ADDR_REF_CFG, 32'h0000_0003);
        span(1'b0, 2);
        check(cyc, 8);
        check(int_mode, 1'b1);
        wb_xfer(1'b1, `FND_ADDR_INT, 32'h0000_0017);
        span(1'b0, 2);
        check(cyc, 24);
        check(int_mode, 1'b0);
        // A fine fraction alone also leaves integer-N operation.
        wb_xfer(1'b1, `FND_ADDR_COARSE, 32'h0000_0000);
        wb_xfer(1'b1, `FND_ADDR_FINE, 32'h0000_0001);
        wb_xfer(1'b1, `FND_ADDR_FINE_MOD, 32'h0000_0002);
        wb_xfer(1'b1, `FND_ADDR_INT, 32'h0000_0017);
        @(posedge core_clk);
        check(int_mode, 1'b0);
        wb_xfer(1'b1, `FND_ADDR_FINE, 32'h0000_0000);
        wb_xfer(1'b1, `FND_ADDR_INT, 32'h0000_0017);
        wb_xfer(1'b1, `FND_ADDR_STATUS, 32'hFFFF_FFFF);
        wb_xfer(1'b0, `FND_ADDR_STATUS, 32'h0);
        check(q, 32'h0002_0017);
        // Field widths: oversize writes keep only the documented bits.
        for (int i = 1; i < 4; i++) begin
            wb_xfer(1'b1, ra[i], 32'hFFFF_FFFF);
            wb_xfer(1'b0, ra[i], 32'h0);
            check(q, (i == 1) ? 32'h00FF_FFFF : 32'h0000_3FFF);
        end
        wb_xfer(1'b1, 8'h18, 32'hFFFF_FFFF);
        wb_xfer(1'b0, 8'h18, 32'h0);
        check(q, 32'h0000_0000);
        // A second reset in mid-run must bring back the reset mode outputs, integer mode, divide value and coarse fraction.
        wb_xfer(1'b1, `FND_ADDR_FINE, 32'h0000_0000);
        wb_xfer(1'b1, `FND_ADDR_REF_CFG, 32'h0000_1000);
        mode_sel <= 1'b1;
        wb_xfer(1'b1, `FND_ADDR_INT, 32'h0000_004B);
        check({diff_en, se_closed, int_mode}, 3'b100);
        @(posedge core_clk);
        reset_n  <= 1'b0;
        mode_sel <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        check({diff_en, se_closed, int_mode, fb_value}, {3'b011, 17'd23});
        wb_xfer(1'b0, `FND_ADDR_COARSE, 32'h0);
        check(q, 32'h0000_0000);
        stop_test();
    end
endmodule // testbench
